// >>> core/dctg_pkg.sv
// Purpose: Constants and types for the timing guard.
// Assumes: Command clock is the system clock divided by CK_DIV.
// Notes: Counts in command clocks.
// =====================================================================
// Overview of operation
// [R1] Row opens spaced by x8/x16 minimum; at most four per rolling window.
// [R2] Column read or write commands at least two clocks apart.
// [R3] Write recovery after data; auto-precharge write blocks row open for total.
// [R4] Read waits write-to-read gap after internal write burst end.
// [R5] Precharge waits read-to-precharge gap after internal read.
// [R6] Clock enable held at each level at least three clocks.
// [R7] Non-read commands wait refresh cycle plus 10 ns after self refresh exit.
// [R8] Reads wait 200 clocks after self refresh exit.
// [R9] Any command waits two clocks after precharge power-down exit.
// [R10] Read waits two clocks after fast active power-down exit.
// [R11] Read waits seven or eight minus additive latency after slow exit.
// [R12] Device turns termination on two clocks after sampling it high.
// [R13] Device turns termination off 2.5 clocks after sampling it low.
// [R14] Termination stable three clocks before power-down entry.
// [R15] Termination changes wait eight clocks after power-down exit.
// [R16] Mode register set spaced two clocks from next command.
// [R17] Device presents calibrated drive within 0 to 12 ns.
// [R18] Clock keeps toggling after clock enable drops.
// [R19] Device strobe single-ended or differential per extended mode bit.
// [R20] Fast or slow active power-down exit chosen by mode set bit A12.
// [R21] Precharge after read no sooner than additive latency plus half burst.
// [R22] Row opens always at least two clocks apart.
// [R23] Nanosecond minimums rounded up to clocks, enforced by down-counters.
package dctg_pkg;
  // =====================================================================
  // Clocking
  localparam int SYS_PERIOD_PS = 100000;
  localparam int CK_DIV = 2;
  localparam int CK_PERIOD_PS = SYS_PERIOD_PS * CK_DIV;
  localparam int TW = 8;
  localparam int NB = 8;
  localparam int AW = 15;
  localparam int BW = 3;

  // [R23] round up to clocks
  function automatic logic [TW-1:0] ps2ck(input int ps);
    int n;
    n = (ps + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
    if (n < 1) n = 1;
    return n[TW-1:0];
  endfunction : ps2ck

  function automatic logic [TW-1:0] mx8(input logic [TW-1:0] a, input logic [TW-1:0] b);
    return (a > b) ? a : b;
  endfunction : mx8

  // =====================================================================
  // Timing figures
  localparam int ROW_OPEN_SPACING_X8_PS = 7500;
  localparam int ROW_OPEN_SPACING_X16_PS = 10000;
  localparam int FOUR_OPEN_WINDOW_X8_667_PS = 37500;
  localparam int FOUR_OPEN_WINDOW_X8_800_PS = 35000;
  localparam int FOUR_OPEN_WINDOW_X16_667_PS = 50000;
  localparam int FOUR_OPEN_WINDOW_X16_800_PS = 45000;
  localparam int WRITE_RECOVERY_PS = 15000;
  localparam int WRITE_TO_READ_GAP_PS = 7500;
  localparam int READ_TO_PRECHARGE_GAP_PS = 7500;
  localparam int SELFREFRESH_EXIT_EXTRA_PS = 10000;
  // Refresh cycle, precharge and row-active figures; plain defaults
  localparam int REFRESH_CYCLE_PS = 200000;
  localparam int PRECHARGE_PS = 15000;
  localparam int ROW_ACTIVE_MIN_PS = 40000;

  localparam logic [TW-1:0] ROW_OPEN_MIN_CK = 8'h02;
  localparam logic [TW-1:0] COLUMN_CMD_SPACING_CK = 8'h02;
  localparam logic [TW-1:0] CLOCK_ENABLE_MIN_PULSE_CK = 8'h03;
  localparam logic [TW-1:0] SELFREFRESH_EXIT_READ_CK = 8'hc8;
  localparam logic [TW-1:0] PRECHARGE_PD_EXIT_CK = 8'h02;
  localparam logic [TW-1:0] ACTIVE_PD_FAST_EXIT_CK = 8'h02;
  localparam logic [TW-1:0] ACTIVE_PD_SLOW_667_CK = 8'h07;
  localparam logic [TW-1:0] ACTIVE_PD_SLOW_800_CK = 8'h08;
  localparam logic [TW-1:0] TERM_TO_PD_ENTRY_CK = 8'h03;
  localparam logic [TW-1:0] TERM_PD_EXIT_CK = 8'h08;
  localparam logic [TW-1:0] MODE_SET_SPACING_CK = 8'h02;

  localparam logic [TW-1:0] RRD_X8_CK = mx8(ps2ck(ROW_OPEN_SPACING_X8_PS), ROW_OPEN_MIN_CK);
  localparam logic [TW-1:0] RRD_X16_CK = mx8(ps2ck(ROW_OPEN_SPACING_X16_PS), ROW_OPEN_MIN_CK);
  localparam logic [TW-1:0] FAW_X8_667_CK = ps2ck(FOUR_OPEN_WINDOW_X8_667_PS);
  localparam logic [TW-1:0] FAW_X8_800_CK = ps2ck(FOUR_OPEN_WINDOW_X8_800_PS);
  localparam logic [TW-1:0] FAW_X16_667_CK = ps2ck(FOUR_OPEN_WINDOW_X16_667_PS);
  localparam logic [TW-1:0] FAW_X16_800_CK = ps2ck(FOUR_OPEN_WINDOW_X16_800_PS);
  localparam logic [TW-1:0] WR_CK = ps2ck(WRITE_RECOVERY_PS);
  localparam logic [TW-1:0] WTR_CK = ps2ck(WRITE_TO_READ_GAP_PS);
  localparam logic [TW-1:0] RTP_CK = ps2ck(READ_TO_PRECHARGE_GAP_PS);
  localparam logic [TW-1:0] RP_CK = ps2ck(PRECHARGE_PS);
  localparam logic [TW-1:0] RAS_CK = ps2ck(ROW_ACTIVE_MIN_PS);
  localparam logic [TW-1:0] RFC_CK = ps2ck(REFRESH_CYCLE_PS);
  localparam logic [TW-1:0] XSNR_CK = ps2ck(REFRESH_CYCLE_PS + SELFREFRESH_EXIT_EXTRA_PS);

  // =====================================================================
  // Pin encodings {ras_n, cas_n, we_n}
  localparam logic [2:0] CODE_NOP = 3'h7;
  localparam logic [2:0] CODE_ACT = 3'h3;
  localparam logic [2:0] CODE_RD = 3'h5;
  localparam logic [2:0] CODE_WR = 3'h4;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_MRS = 3'h0;
  localparam int AUTO_PRE_BIT = 10;
  localparam int MR_EXIT_BIT = 12;
  localparam logic [BW-1:0] BANK_MR = 3'h0;
  localparam logic [BW-1:0] BANK_EMR = 3'h1;

  // =====================================================================
  // Timer slots
  localparam int T_RRD = 0;
  localparam int T_CCD = 1;
  localparam int T_WTR = 2;
  localparam int T_MRD = 3;
  localparam int T_CKE = 4;
  localparam int T_ANY = 5;
  localparam int T_RDX = 6;
  localparam int T_AXPD = 7;
  localparam int T_ODT = 8;
  localparam int T_PRE0 = 9;
  localparam int T_ACT0 = T_PRE0 + NB;
  localparam int T_FAW0 = T_ACT0 + NB;
  localparam int NT = T_FAW0 + 4;

  // =====================================================================
  // Types
  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_RDA, OP_WR, OP_WRA, OP_PRE, OP_PREA,
    OP_REF, OP_MRS, OP_EXTENDED_MODE_SET, OP_SRE, OP_SRX, OP_PDE, OP_PDX
  } dctg_op_t;

  typedef enum logic [1:0] {PWR_ACT, PWR_SELF, PWR_PPD, PWR_APD} dctg_pwr_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [BW-1:0] ba;
    logic [AW-1:0] addr;
  } dctg_pins_t;
endpackage : dctg_pkg

// >>> core/dctg_timer.sv
// Purpose: Hold-off down-counter.
// Assumes: Ticks on command clock fall.
// Notes: A load never shortens a wait already running.
`timescale 1ns/1ps
module dctg_timer import dctg_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [TW-1:0] val_i,
  output logic zero_o
);
  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;
  logic [TW-1:0] ld;

  // =====================================================================
  // Count
  always_comb begin
    ld = (val_i == 8'h00) ? 8'h00 : val_i - 8'h01;
    cnt_next = cnt_reg;
    // [R23] down-counter hold-off
    if (load_i) begin
      cnt_next = mx8(cnt_reg, ld);
    end else if (tick_i && cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign zero_o = (cnt_reg == 8'h00);
endmodule : dctg_timer

// >>> core/dctg_top.sv
// Purpose: Host DDR2 command issuer with spacing guard.
// Assumes: Request held until req_done_o.
// Notes: Pins change as ck_o falls, half a clock early.
`timescale 1ns/1ps
module dctg_top import dctg_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire dctg_op_t req_op_i,
  input wire logic [BW-1:0] req_bank_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic odt_req_i,
  input wire logic cfg_x16_i,
  input wire logic cfg_800_i,
  input wire logic [2:0] cfg_al_i,
  input wire logic [2:0] cfg_cl_i,
  input wire logic cfg_bl8_i,
  output logic req_done_o,
  output logic ck_o,
  output dctg_pins_t pins_o,
  output dctg_pwr_t pwr_o,
  output logic slow_exit_o
);
  logic ck_reg, ck_next;
  logic done_reg, done_next;
  dctg_pins_t pins_reg, pins_next;
  dctg_pwr_t pwr_reg, pwr_next;
  logic slow_reg, slow_next;
  logic [NB-1:0] open_reg, open_next;
  logic [1:0] faw_reg, faw_next;
  logic [NT-1:0] t_zero;
  logic [NT-1:0] t_load;
  logic [TW-1:0] t_val [NT];
  logic tick, legal, issue, odt_chg;
  logic [TW-1:0] al8, hb, wend, rdpre, slowx, slowb;
  int b, fs;

  // =====================================================================
  // Timers
  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tmr
      dctg_timer u_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .load_i(t_load[g]),
        .val_i(t_val[g]),
        .zero_o(t_zero[g])
      );
    end
  endgenerate

  // =====================================================================
  // Issue decision
  always_comb begin
    tick = ce_i & ck_reg;
    b = int'(req_bank_i);
    fs = T_FAW0 + int'(faw_reg);
    al8 = {5'h00, cfg_al_i};
    hb = cfg_bl8_i ? 8'h04 : 8'h02;
    // Write burst ends at write latency plus half burst
    wend = al8 + {5'h00, cfg_cl_i} - 8'h01 + hb;
    // [R21] read to precharge
    rdpre = al8 + mx8(hb, RTP_CK);
    slowb = cfg_800_i ? ACTIVE_PD_SLOW_800_CK : ACTIVE_PD_SLOW_667_CK;
    // [R11] slow exit minus latency
    slowx = (slowb > al8) ? slowb - al8 : 8'h01;
    legal = 1'b0;
    unique case (req_op_i)
      OP_NOP: legal = pwr_reg == PWR_ACT && t_zero[T_ANY] && t_zero[T_MRD];
      // [R1] spacing and window
      OP_ACT: legal = pwr_reg == PWR_ACT && t_zero[T_RRD] && t_zero[fs] && t_zero[T_ACT0 + b]
        && t_zero[T_ANY] && t_zero[T_MRD];
      // [R4] write to read
      OP_RD, OP_RDA: legal = pwr_reg == PWR_ACT && t_zero[T_CCD] && t_zero[T_WTR]
        && t_zero[T_RDX] && t_zero[T_MRD];
      OP_WR, OP_WRA: legal = pwr_reg == PWR_ACT && t_zero[T_CCD] && t_zero[T_ANY]
        && t_zero[T_MRD];
      // [R5] precharge hold-off
      OP_PRE: legal = pwr_reg == PWR_ACT && t_zero[T_PRE0 + b] && t_zero[T_ANY] && t_zero[T_MRD];
      OP_PREA: legal = pwr_reg == PWR_ACT && (&t_zero[T_PRE0 +: NB]) && t_zero[T_ANY]
        && t_zero[T_MRD];
      OP_REF, OP_MRS, OP_EXTENDED_MODE_SET: legal = pwr_reg == PWR_ACT && open_reg == 8'h00
        && (&t_zero[T_ACT0 +: NB]) && t_zero[T_ANY] && t_zero[T_MRD];
      // [R14] termination settled first
      OP_SRE: legal = pwr_reg == PWR_ACT && open_reg == 8'h00 && (&t_zero[T_ACT0 +: NB])
        && t_zero[T_CKE] && t_zero[T_ODT] && t_zero[T_ANY] && t_zero[T_MRD];
      OP_PDE: legal = pwr_reg == PWR_ACT && t_zero[T_CKE] && t_zero[T_ODT] && t_zero[T_ANY]
        && t_zero[T_MRD];
      // [R6] clock enable pulse
      OP_SRX: legal = pwr_reg == PWR_SELF && t_zero[T_CKE];
      OP_PDX: legal = (pwr_reg == PWR_PPD || pwr_reg == PWR_APD) && t_zero[T_CKE];
      default: legal = 1'b0;
    endcase
    issue = tick & req_valid_i & legal;
    // [R15] no termination change within eight clocks of exit
    odt_chg = tick && odt_req_i != pins_reg.odt && t_zero[T_AXPD] && pwr_reg == PWR_ACT
      && !(issue && (req_op_i == OP_SRE || req_op_i == OP_PDE));
  end

  // =====================================================================
  // Timer loads
  always_comb begin
    t_load = '0;
    for (int i = 0; i < NT; i++) begin
      t_val[i] = 8'h00;
    end
    if (odt_chg) begin
      t_load[T_ODT] = 1'b1;
      t_val[T_ODT] = TERM_TO_PD_ENTRY_CK;
    end
    if (issue) begin
      unique case (req_op_i)
        OP_ACT: begin
          // [R22] two-clock floor
          t_load[T_RRD] = 1'b1;
          t_val[T_RRD] = cfg_x16_i ? RRD_X16_CK : RRD_X8_CK;
          t_load[fs] = 1'b1;
          t_val[fs] = cfg_x16_i ? (cfg_800_i ? FAW_X16_800_CK : FAW_X16_667_CK)
            : (cfg_800_i ? FAW_X8_800_CK : FAW_X8_667_CK);
          t_load[T_PRE0 + b] = 1'b1;
          t_val[T_PRE0 + b] = RAS_CK;
        end
        OP_RD, OP_RDA: begin
          // [R2] column spacing
          t_load[T_CCD] = 1'b1;
          t_val[T_CCD] = COLUMN_CMD_SPACING_CK;
          t_load[T_PRE0 + b] = 1'b1;
          t_val[T_PRE0 + b] = rdpre;
          t_load[T_ACT0 + b] = req_op_i == OP_RDA;
          t_val[T_ACT0 + b] = rdpre + RP_CK;
        end
        OP_WR, OP_WRA: begin
          t_load[T_CCD] = 1'b1;
          t_val[T_CCD] = COLUMN_CMD_SPACING_CK;
          t_load[T_WTR] = 1'b1;
          t_val[T_WTR] = wend + WTR_CK;
          // [R3] recovery and auto-precharge total
          t_load[T_PRE0 + b] = 1'b1;
          t_val[T_PRE0 + b] = wend + WR_CK;
          t_load[T_ACT0 + b] = req_op_i == OP_WRA;
          t_val[T_ACT0 + b] = wend + WR_CK + RP_CK;
        end
        OP_PRE: begin
          t_load[T_ACT0 + b] = 1'b1;
          t_val[T_ACT0 + b] = RP_CK;
        end
        OP_PREA: begin
          for (int k = 0; k < NB; k++) begin
            t_load[T_ACT0 + k] = 1'b1;
            t_val[T_ACT0 + k] = RP_CK;
          end
        end
        OP_REF: begin
          t_load[T_ANY] = 1'b1;
          t_val[T_ANY] = RFC_CK;
        end
        OP_MRS, OP_EXTENDED_MODE_SET: begin
          // [R16] mode set spacing
          t_load[T_MRD] = 1'b1;
          t_val[T_MRD] = MODE_SET_SPACING_CK;
        end
        OP_SRE, OP_PDE: begin
          t_load[T_CKE] = 1'b1;
          t_val[T_CKE] = CLOCK_ENABLE_MIN_PULSE_CK;
        end
        OP_SRX: begin
          t_load[T_CKE] = 1'b1;
          t_val[T_CKE] = CLOCK_ENABLE_MIN_PULSE_CK;
          // [R7] non-read after self refresh
          t_load[T_ANY] = 1'b1;
          t_val[T_ANY] = XSNR_CK;
          // [R8] read after self refresh
          t_load[T_RDX] = 1'b1;
          t_val[T_RDX] = SELFREFRESH_EXIT_READ_CK;
          t_load[T_AXPD] = 1'b1;
          t_val[T_AXPD] = TERM_PD_EXIT_CK;
        end
        OP_PDX: begin
          t_load[T_CKE] = 1'b1;
          t_val[T_CKE] = CLOCK_ENABLE_MIN_PULSE_CK;
          // [R9] precharge power-down exit
          t_load[T_ANY] = pwr_reg == PWR_PPD;
          t_val[T_ANY] = PRECHARGE_PD_EXIT_CK;
          // [R10] active exit speed
          t_load[T_RDX] = 1'b1;
          t_val[T_RDX] = pwr_reg == PWR_PPD ? PRECHARGE_PD_EXIT_CK
            : (slow_reg ? slowx : ACTIVE_PD_FAST_EXIT_CK);
          t_load[T_AXPD] = 1'b1;
          t_val[T_AXPD] = TERM_PD_EXIT_CK;
        end
        default: ;
      endcase
    end
  end

  // =====================================================================
  // Pins and state
  always_comb begin
    // [R18] free-running command clock
    ck_next = ce_i ? ~ck_reg : ck_reg;
    done_next = ce_i ? issue : done_reg;
    pins_next = pins_reg;
    pwr_next = pwr_reg;
    slow_next = slow_reg;
    open_next = open_reg;
    faw_next = faw_reg;
    if (tick) begin
      {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = CODE_NOP;
    end
    if (odt_chg) begin
      pins_next.odt = odt_req_i;
    end
    if (issue) begin
      pins_next.ba = req_bank_i;
      pins_next.addr = req_addr_i;
      unique case (req_op_i)
        OP_NOP: ;
        OP_ACT: begin
          {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = CODE_ACT;
          open_next[b] = 1'b1;
          faw_next = faw_reg + 2'h1;
        end
        OP_RD, OP_RDA, OP_WR, OP_WRA: begin
          {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} =
            (req_op_i == OP_RD || req_op_i == OP_RDA) ? CODE_RD : CODE_WR;
          pins_next.addr[AUTO_PRE_BIT] = req_op_i == OP_RDA || req_op_i == OP_WRA;
          if (req_op_i == OP_RDA || req_op_i == OP_WRA) open_next[b] = 1'b0;
        end
        OP_PRE, OP_PREA: begin
          {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = CODE_PRE;
          pins_next.addr[AUTO_PRE_BIT] = req_op_i == OP_PREA;
          if (req_op_i == OP_PREA) open_next = 8'h00;
          else open_next[b] = 1'b0;
        end
        OP_REF: {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = CODE_REF;
        OP_MRS, OP_EXTENDED_MODE_SET: begin
          {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = CODE_MRS;
          pins_next.ba = req_op_i == OP_MRS ? BANK_MR : BANK_EMR;
          // [R20] exit speed from A12
          if (req_op_i == OP_MRS) slow_next = req_addr_i[MR_EXIT_BIT];
        end
        OP_SRE: begin
          {pins_next.ras_n, pins_next.cas_n, pins_next.we_n} = CODE_REF;
          pins_next.cke = 1'b0;
          pwr_next = PWR_SELF;
        end
        OP_PDE: begin
          pins_next.cke = 1'b0;
          pwr_next = open_reg != 8'h00 ? PWR_APD : PWR_PPD;
        end
        OP_SRX, OP_PDX: begin
          pins_next.cke = 1'b1;
          pwr_next = PWR_ACT;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ck_reg <= 1'b0;
      done_reg <= 1'b0;
      pins_reg <= '{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
        odt: 1'b0, ba: 3'h0, addr: 15'h0000};
      pwr_reg <= PWR_ACT;
      slow_reg <= 1'b0;
      open_reg <= 8'h00;
      faw_reg <= 2'h0;
    end else begin
      ck_reg <= ck_next;
      done_reg <= done_next;
      pins_reg <= pins_next;
      pwr_reg <= pwr_next;
      slow_reg <= slow_next;
      open_reg <= open_next;
      faw_reg <= faw_next;
    end
  end

  assign ck_o = ck_reg;
  assign req_done_o = done_reg;
  assign pins_o = pins_reg;
  assign pwr_o = pwr_reg;
  assign slow_exit_o = slow_reg;
endmodule : dctg_top

// >>> test/dctg_checker.sv
// Purpose: Command spacing checks at the guard's ports.
// Assumes: One command clock is two sys cycles.
// Notes: Saturating gap counters; stale events never fire.
`timescale 1ns/1ps
module dctg_checker import dctg_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cfg_800_i,
  input wire logic [2:0] cfg_al_i,
  input wire logic [2:0] cfg_cl_i,
  input wire logic cfg_bl8_i,
  input wire logic req_done_o,
  input wire dctg_pins_t pins_o,
  input wire dctg_pwr_t pwr_o,
  input wire logic slow_exit_o
);
  // =====================================================================
  // Gap counters in sys cycles
  logic [2:0] code;
  logic is_act, is_rd, is_wr, is_pre, exit_ev;
  int wtr_sys, rtp_sys, apd_sys, slow_ck;
  logic [9:0] wr_reg, wr_next, rd_reg, rd_next, ex_reg, ex_next;
  dctg_pwr_t pwr_reg, from_reg, from_next;
  always_comb begin
    code = {pins_o.ras_n, pins_o.cas_n, pins_o.we_n};
    is_act = req_done_o && code == CODE_ACT;
    is_rd = req_done_o && code == CODE_RD;
    is_wr = req_done_o && code == CODE_WR;
    is_pre = req_done_o && code == CODE_PRE;
    exit_ev = pwr_reg != PWR_ACT && pwr_o == PWR_ACT;
    wtr_sys = 2 * (int'(cfg_al_i) + int'(cfg_cl_i) + (cfg_bl8_i ? 4 : 2));
    rtp_sys = 2 * (int'(cfg_al_i) + (cfg_bl8_i ? 4 : 2));
    slow_ck = (cfg_800_i ? 8 : 7) - int'(cfg_al_i);
    apd_sys = slow_exit_o ? 2 * ((slow_ck < 1) ? 1 : slow_ck) : 4;
    wr_next = is_wr ? 10'h001 : wr_reg + {9'h000, wr_reg != 10'h3ff};
    rd_next = is_rd ? 10'h001 : rd_reg + {9'h000, rd_reg != 10'h3ff};
    ex_next = exit_ev ? 10'h001 : ex_reg + {9'h000, ex_reg != 10'h3ff};
    from_next = exit_ev ? pwr_reg : from_reg;
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_reg <= 10'h3ff;
      rd_reg <= 10'h3ff;
      ex_reg <= 10'h3ff;
      pwr_reg <= PWR_ACT;
      from_reg <= PWR_ACT;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      ex_reg <= ex_next;
      pwr_reg <= pwr_o;
      from_reg <= from_next;
    end
  end
  // =====================================================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_act_spacing: assert property (is_act |=> !is_act [*3])
    else $error("row open gap");
  a_col_spacing: assert property ((is_rd || is_wr) |=> !(is_rd || is_wr) [*3])
    else $error("column gap");
  a_mode_spacing: assert property (req_done_o && code == CODE_MRS |=> !req_done_o [*3])
    else $error("mode set gap");
  a_cke_pulse: assert property ($changed(pins_o.cke) && !$past(rst_i) |=> $stable(pins_o.cke) [*5])
    else $error("cke pulse");
  a_write_read: assert property (is_rd |-> wr_reg >= wtr_sys)
    else $error("write to read");
  a_write_recovery: assert property (is_pre |-> wr_reg >= wtr_sys)
    else $error("write recovery");
  a_read_pre: assert property (is_pre |-> rd_reg >= rtp_sys)
    else $error("read to precharge");
  a_sr_nonread: assert property (req_done_o && !is_rd && from_reg == PWR_SELF |-> ex_reg >= 4)
    else $error("sr exit command");
  a_sr_read: assert property (is_rd && from_reg == PWR_SELF |-> ex_reg >= 400)
    else $error("sr exit read");
  a_ppd_exit: assert property (req_done_o && from_reg == PWR_PPD |-> ex_reg >= 4)
    else $error("pd exit command");
  a_apd_read: assert property (is_rd && from_reg == PWR_APD |-> ex_reg >= apd_sys)
    else $error("apd exit read");
  a_term_entry: assert property ($changed(pins_o.odt) && !$past(rst_i) |=> pwr_o == PWR_ACT [*5])
    else $error("odt before pd");
  a_term_exit: assert property ($changed(pins_o.odt) |-> ex_reg >= 16)
    else $error("odt after exit");
  c_act_pair: cover property (is_act ##4 is_act);
  c_sr_exit: cover property (exit_ev && pwr_reg == PWR_SELF);
  c_slow_read: cover property (is_rd && from_reg == PWR_APD && slow_exit_o);
endmodule : dctg_checker

// >>> test/dctg_dev_model.sv
// Purpose: Device model watching the command pins.
// Assumes: Pins settle before ck_i rises.
// Notes: Power-down termination uses synchronous timing.
`timescale 1ns/1ps
module dctg_dev_model import dctg_pkg::*; #(
  parameter int STROBE_OFF_BIT = 10,
  parameter int DRIVE_BIT = 7
) (
  input wire logic ck_i,
  input wire dctg_pins_t pins_i,
  output logic term_on_o,
  output logic strobe_diff_o,
  output logic drive_cal_o
);
  logic s1 = 1'b0, s2 = 1'b0, on_p = 1'b0, on_n = 1'b0;
  initial strobe_diff_o = 1'b1;
  initial drive_cal_o = 1'b0;
  always @(posedge ck_i) begin
    s1 <= pins_i.odt;
    s2 <= s1;
    on_p <= s2;
  end
  // off half a clock later still
  always @(negedge ck_i) on_n <= on_p;
  assign term_on_o = on_p | on_n;
  always @(posedge ck_i) begin
    if (!pins_i.cs_n && {pins_i.ras_n, pins_i.cas_n, pins_i.we_n} == CODE_MRS &&
        pins_i.ba == BANK_EMR) begin
      strobe_diff_o <= !pins_i.addr[STROBE_OFF_BIT];
      drive_cal_o <= pins_i.addr[DRIVE_BIT];
    end
  end
endmodule : dctg_dev_model

// >>> test/dctg_top_tb_top.sv
// Purpose: Bench for the command timing guard.
// Assumes: Gaps in sys cycles, two per command clock.
// Notes: Refused requests time out.
`timescale 1ns/1ps
module dctg_top_tb_top import dctg_pkg::*;;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, odt_req_i = 1'b0, ce_i = 1'b1;
  logic cfg_x16_i = 1'b0, cfg_800_i = 1'b0, cfg_bl8_i = 1'b1;
  dctg_op_t req_op_i = OP_NOP;
  logic [BW-1:0] req_bank_i = 3'h0;
  logic [AW-1:0] req_addr_i = 15'h0000;
  logic [2:0] cfg_al_i = 3'h1, cfg_cl_i = 3'h4;
  logic req_done_o, ck_o, slow_exit_o, term_on, strobe_diff, drive_cal, ck_seen;
  dctg_pins_t pins_o;
  dctg_pwr_t pwr_o;
  int fails = 0, tests_run = 0, cyc = 0, t0, t1, t2, t3;
  dctg_top DUT (.*);
  dctg_dev_model u_dev (.ck_i(ck_o), .pins_i(pins_o), .term_on_o(term_on),
    .strobe_diff_o(strobe_diff), .drive_cal_o(drive_cal));
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  // =====================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic issue(input dctg_op_t op, input logic [BW-1:0] ba, input logic [AW-1:0] a,
                       input int lim, output int t);
    @(negedge sys_clk_i);
    req_op_i = op;
    req_bank_i = ba;
    req_addr_i = a;
    req_valid_i = 1'b1;
    t = -1;
    for (int i = 0; i < lim && t < 0; i++) begin
      @(negedge sys_clk_i);
      if (req_done_o === 1'b1) t = cyc;
    end
    req_valid_i = 1'b0;
  endtask : issue
  task automatic wait_odt(input logic v, output int t);
    t = -1;
    for (int i = 0; i < 200 && t < 0; i++) begin
      @(negedge sys_clk_i);
      if (pins_o.odt === v) t = cyc;
    end
  endtask : wait_odt
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic cmd(input dctg_op_t op, input int lim, output int t);
    issue(op, 3'h0, 15'h0000, lim, t);
  endtask : cmd
  // =====================================================================
  // Scenarios
  task automatic t_mode();
    ce_i = 1'b0;
    ck_seen = ck_o;
    repeat (3) @(negedge sys_clk_i);
    chk("ck_o_frozen", ck_seen, ck_o);
    ce_i = 1'b1;
    chk("pins_o", 24'hb80000, pins_o);
    issue(OP_MRS, BANK_MR, 15'h1000, 20, t0);
    issue(OP_EXTENDED_MODE_SET, BANK_EMR, 15'h0480, 20, t1);
    chk("mode_set_gap", 4, t1 - t0);
    chk("slow_exit_o", 1'b1, slow_exit_o);
    repeat (2) @(negedge sys_clk_i);
    chk("strobe_diff", 1'b0, strobe_diff);
    chk("drive_cal", 1'b1, drive_cal);
  endtask : t_mode
  task automatic t_rows();
    for (int k = 0; k < 4; k++) begin
      cfg_x16_i = k[0];
      cfg_800_i = k[1];
      cmd(OP_PREA, 20, t0);
      issue(OP_ACT, 3'h0, 15'h0011, 20, t0);
      for (int b = 1; b < 5; b++) begin
        issue(OP_ACT, b[BW-1:0], 15'h0011, 20, t1);
        chk("row_open_gap", 4, t1 - t0);
        t0 = t1;
      end
    end
  endtask : t_rows
  task automatic t_column();
    cmd(OP_PREA, 20, t0);
    issue(OP_ACT, 3'h0, 15'h0022, 20, t0);
    issue(OP_WR, 3'h0, 15'h0008, 20, t0);
    issue(OP_RD, 3'h0, 15'h0008, 60, t1);
    chk("write_to_read_gap", 18, t1 - t0);
    issue(OP_RD, 3'h0, 15'h0010, 20, t2);
    chk("column_cmd_gap", 4, t2 - t1);
    cmd(OP_PRE, 60, t3);
    chk("read_to_precharge_gap", 10, t3 - t2);
    issue(OP_ACT, 3'h0, 15'h0022, 60, t0);
    issue(OP_WRA, 3'h0, 15'h0008, 20, t0);
    issue(OP_ACT, 3'h0, 15'h0022, 60, t1);
    chk("autoprecharge_write_total", 20, t1 - t0);
    issue(OP_ACT, 3'h1, 15'h0033, 20, t0);
    issue(OP_WR, 3'h1, 15'h0008, 20, t0);
    issue(OP_PRE, 3'h1, 15'h0000, 60, t1);
    chk("write_recovery", 18, t1 - t0);
  endtask : t_column
  task automatic t_power();
    cmd(OP_PDX, 20, t0);
    chk("pdx_refused", 32'hffffffff, t0);
    cmd(OP_PREA, 60, t0);
    odt_req_i = 1'b1;
    wait_odt(1'b1, t0);
    cmd(OP_PDE, 20, t1);
    chk("term_to_pd_entry", 6, t1 - t0);
    chk("term_on", 1'b1, term_on);
    chk("pwr_o", PWR_PPD, pwr_o);
    ck_seen = ck_o;
    @(negedge sys_clk_i);
    chk("ck_o_runs", !ck_seen, ck_o);
    cmd(OP_PDX, 20, t2);
    chk("clock_enable_min_pulse", 6, t2 - t1);
    odt_req_i = 1'b0;
    cmd(OP_NOP, 20, t3);
    chk("precharge_pd_exit", 4, t3 - t2);
    wait_odt(1'b0, t0);
    chk("term_pd_exit", 16, t0 - t2);
    repeat (8) @(negedge sys_clk_i);
    chk("term_off", 1'b0, term_on);
  endtask : t_power
  task automatic t_apd();
    for (int k = 0; k < 4; k++) begin
      cfg_800_i = k[1];
      issue(OP_MRS, BANK_MR, {2'h0, k[0], 12'h000}, 20, t0);
      issue(OP_ACT, 3'h2, 15'h0044, 60, t0);
      cmd(OP_PDE, 60, t0);
      chk("pwr_o", PWR_APD, pwr_o);
      cmd(OP_PDX, 20, t0);
      issue(OP_RD, 3'h2, 15'h0008, 60, t1);
      chk("active_pd_exit", k[0] ? (k[1] ? 14 : 12) : 4, t1 - t0);
      cmd(OP_PREA, 60, t0);
    end
  endtask : t_apd
  task automatic t_selfref();
    cmd(OP_SRE, 60, t0);
    chk("pwr_o", PWR_SELF, pwr_o);
    cmd(OP_SRX, 20, t1);
    cmd(OP_NOP, 20, t2);
    chk("selfrefresh_exit_nonread", 4, t2 - t1);
    issue(OP_RD, 3'h0, 15'h0008, 600, t3);
    chk("selfrefresh_exit_read", 400, t3 - t1);
  endtask : t_selfref
  // =====================================================================
  // Sequence and watchdog
  initial begin
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_mode();
    t_rows();
    t_column();
    t_power();
    t_apd();
    t_selfref();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    wrap_up();
  end
endmodule : dctg_top_tb_top
bind dctg_top dctg_checker u_chk (.*);
